// ### hdl/sart_top.sv
`timescale 1ns/1ps
`default_nettype none
module sart_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	output logic rx_full_irq,
	output logic rx_error_irq,
	output logic tx_empty_irq,
	output logic tx_end_irq
);
	import sart_pkg::*;
	logic [7:0] fmt_ff, baud_div_ff, ctl_ff, tx_data_ff, rx_buf_ff;
	logic [7:0] rx_sh_ff, tx_sh_ff, sts;
	logic [1:0] pfn_ff;
	logic [31:0] prdata_ff;
	logic tx_empty_ff, rx_full_ff, ovr_ff, frm_ff, par_ff, tend_ff;
	logic mpb_ff, mpbt_ff;
	logic s1_ff, s2_ff, s3_ff, rx_lvl_ff, rx_prev_ff;
	logic tick, rx_go, fall, samp, rx_done, id_eff, accept;
	logic rx_parity_ff, rx_mpb_ff, tx_parity_ff;
	logic [3:0] rx_cnt_ff, tx_cnt_ff;
	logic [2:0] rx_idx_ff, tx_idx_ff, last_bit;
	logic txo_ff, tx_bit_end, tx_load, mp_fmt, extra_bit;
	logic acc, wr, mapped;
	logic wr_fmt, wr_div, wr_ctl, wr_txd, wr_sts, wr_pfn;
	sart_rx_e rx_st_ff;
	sart_tx_e tx_st_ff;

	sart_baud u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.pre_sel(fmt_ff[1:0]),
		.divisor(baud_div_ff),
		.tick(tick)
	);

	// apb decode; zero wait states, reads captured in the setup cycle
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign mapped = (paddr == OFF_FMT) || (paddr == OFF_DIV) ||
		(paddr == OFF_CTL) || (paddr == OFF_TXD) || (paddr == OFF_STS) ||
		(paddr == OFF_RXD) || (paddr == OFF_PFN);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign wr_fmt = wr && (paddr == OFF_FMT);
	assign wr_div = wr && (paddr == OFF_DIV);
	assign wr_ctl = wr && (paddr == OFF_CTL);
	assign wr_txd = wr && (paddr == OFF_TXD);
	assign wr_sts = wr && (paddr == OFF_STS);
	assign wr_pfn = wr && (paddr == OFF_PFN);
	assign prdata = prdata_ff;

	assign sts = {tx_empty_ff, rx_full_ff, ovr_ff, frm_ff, par_ff, tend_ff,
		mpb_ff, mpbt_ff};

	// read data latched at the setup edge, held through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_FMT: prdata_ff <= {24'h000000, fmt_ff};
				OFF_DIV: prdata_ff <= {24'h000000, baud_div_ff};
				OFF_CTL: prdata_ff <= {24'h000000, ctl_ff};
				OFF_TXD: prdata_ff <= {24'h000000, tx_data_ff};
				OFF_STS: prdata_ff <= {24'h000000, sts};
				OFF_RXD: prdata_ff <= {24'h000000, rx_buf_ff};
				OFF_PFN: prdata_ff <= {30'h0, pfn_ff};
				default: prdata_ff <= 32'h00000000;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_ff <= FMT_RST;
			baud_div_ff <= DIV_RST;
			pfn_ff <= PFN_RST;
		end else begin
			if (wr_fmt)
				fmt_ff <= pwdata[7:0]; // [R16]
			if (wr_div)
				baud_div_ff <= pwdata[7:0]; // [R15]
			if (wr_pfn)
				pfn_ff <= pwdata[1:0];
		end
	end

	// control; an address character clears the id wait bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_ff <= CTL_RST;
		end else begin
			if (wr_ctl)
				ctl_ff <= pwdata[7:0];
			if (rx_done && id_eff && rx_mpb_ff)
				ctl_ff[CTL_ID_WAIT_ENABLE] <= 1'b0; // [R05] [R07]
		end
	end

	// three stage input; level moves once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			rx_lvl_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			s1_ff <= serial_in_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				rx_lvl_ff <= s2_ff;
			rx_prev_ff <= rx_lvl_ff;
		end
	end

	// receiver control terms
	assign rx_go = ctl_ff[CTL_RE] && pfn_ff[PFN_RX]; // [R01] [R14]
	assign fall = rx_prev_ff && !rx_lvl_ff; // [R09]
	assign samp = tick && (rx_cnt_ff == OVS_MID); // [R09]
	assign mp_fmt = fmt_ff[FMT_MP] && !fmt_ff[FMT_SYNC];
	assign extra_bit = mp_fmt || fmt_ff[FMT_PEN];
	assign last_bit = fmt_ff[FMT_CHR7] ? LAST_BIT7 : LAST_BIT8;
	assign id_eff = ctl_ff[CTL_ID_WAIT_ENABLE] && mp_fmt; // [R04]
	assign rx_done = (rx_st_ff == R_STOP) && samp && rx_go; // [R02]
	assign accept = !id_eff || rx_mpb_ff; // [R06]

	// receive sequencer; leaving rx_on drops only the frame in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_ff <= R_IDLE;
			rx_cnt_ff <= 4'h0;
			rx_idx_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_parity_ff <= 1'b0;
			rx_mpb_ff <= 1'b0;
		end else if (!rx_go) begin
			rx_st_ff <= R_IDLE; // [R01] [R02]
		end else begin
			if (tick)
				rx_cnt_ff <= rx_cnt_ff + 4'h1;
			case (rx_st_ff)
				R_IDLE: begin
					if (fall) begin
						rx_st_ff <= R_START; // [R03] [R09]
						rx_cnt_ff <= 4'h0;
					end
				end
				R_START: begin
					if (samp) begin
						// a glitch shorter than half a bit is no start
						rx_st_ff <= rx_lvl_ff ? R_IDLE : R_DATA; // [R09]
						rx_idx_ff <= 3'h0;
						rx_parity_ff <= 1'b0;
						rx_mpb_ff <= 1'b0;
					end
				end
				R_DATA: begin
					if (samp) begin
						rx_sh_ff <= {rx_lvl_ff, rx_sh_ff[7:1]}; // [R08]
						rx_parity_ff <= rx_parity_ff ^ rx_lvl_ff;
						rx_idx_ff <= rx_idx_ff + 3'h1;
						if (rx_idx_ff == last_bit)
							rx_st_ff <= extra_bit ? R_EXTRA : R_STOP;
					end
				end
				R_EXTRA: begin
					if (samp) begin
						rx_mpb_ff <= mp_fmt && rx_lvl_ff;
						rx_parity_ff <= rx_parity_ff ^ rx_lvl_ff;
						rx_st_ff <= R_STOP;
					end
				end
				R_STOP: begin
					// only the first stop bit is checked
					if (samp)
						rx_st_ff <= R_IDLE;
				end
				default: rx_st_ff <= R_IDLE;
			endcase
		end
	end

	// receive flags: set wins over a write-0 clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_ff <= 1'b0;
			ovr_ff <= 1'b0;
			frm_ff <= 1'b0;
			par_ff <= 1'b0;
			mpb_ff <= 1'b0;
			rx_buf_ff <= 8'h00;
		end else begin
			if (wr_sts && !pwdata[STS_RX_FULL_FLAG])
				rx_full_ff <= 1'b0;
			if (wr_sts && !pwdata[STS_OVERRUN_FLAG])
				ovr_ff <= 1'b0;
			if (wr_sts && !pwdata[STS_FER])
				frm_ff <= 1'b0;
			if (wr_sts && !pwdata[STS_PER])
				par_ff <= 1'b0;
			if (rx_done && accept) begin // [R06] [R07]
				mpb_ff <= rx_mpb_ff; // [R07]
				if (rx_full_ff) begin
					ovr_ff <= 1'b1; // buffer kept, new character lost
				end else begin
					rx_full_ff <= 1'b1; // [R10]
					rx_buf_ff <= fmt_ff[FMT_CHR7] ?
						{1'b0, rx_sh_ff[7:1]} : rx_sh_ff;
					if (!rx_lvl_ff)
						frm_ff <= 1'b1; // [R16]
					if (fmt_ff[FMT_PEN] && !mp_fmt &&
						(rx_parity_ff != fmt_ff[FMT_ODD]))
						par_ff <= 1'b1; // [R16]
				end
			end
		end
	end

	// transmit holding register and its flags
	assign tx_load = (tx_st_ff == T_IDLE) && ctl_ff[CTL_TE] && !tx_empty_ff;
	assign tx_bit_end = tick && (tx_cnt_ff == OVS_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_ff <= 8'h00;
			tx_empty_ff <= 1'b1;
			tend_ff <= 1'b1;
			mpbt_ff <= 1'b0;
		end else begin
			if (wr_sts)
				mpbt_ff <= pwdata[STS_MPBT];
			if (wr_txd) begin
				tx_data_ff <= pwdata[7:0]; // [R10]
				tx_empty_ff <= 1'b0;
				tend_ff <= 1'b0;
			end
			if (tx_load)
				tx_empty_ff <= 1'b1;
			if ((tx_st_ff == T_STOP) && tx_bit_end &&
				(tx_idx_ff[0] || !fmt_ff[FMT_STOP2]) && tx_empty_ff)
				tend_ff <= 1'b1;
			if (!ctl_ff[CTL_TE])
				tx_empty_ff <= 1'b1; // [R11]
		end
	end

	// transmit sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_ff <= T_IDLE;
			tx_sh_ff <= 8'h00;
			tx_cnt_ff <= 4'h0;
			tx_idx_ff <= 3'h0;
			tx_parity_ff <= 1'b0;
			txo_ff <= 1'b1;
		end else if (!ctl_ff[CTL_TE]) begin
			tx_st_ff <= T_IDLE; // [R11]
			tx_sh_ff <= 8'h00; // [R11]
			txo_ff <= 1'b1;
		end else begin
			if (tick)
				tx_cnt_ff <= tx_cnt_ff + 4'h1;
			case (tx_st_ff)
				T_IDLE: begin
					txo_ff <= 1'b1; // [R08]
					if (tx_load) begin
						tx_sh_ff <= tx_data_ff;
						tx_parity_ff <= 1'b0;
						tx_cnt_ff <= 4'h0;
						tx_st_ff <= T_START;
						txo_ff <= 1'b0; // [R08]
					end
				end
				T_START: begin
					if (tx_bit_end) begin
						tx_st_ff <= T_DATA;
						tx_idx_ff <= 3'h0;
						txo_ff <= tx_sh_ff[0]; // [R08]
					end
				end
				T_DATA: begin
					if (tx_bit_end) begin
						tx_parity_ff <= tx_parity_ff ^ tx_sh_ff[0];
						tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
						tx_idx_ff <= tx_idx_ff + 3'h1;
						txo_ff <= tx_sh_ff[1];
						if (tx_idx_ff == last_bit) begin
							tx_st_ff <= extra_bit ? T_EXTRA : T_STOP;
							tx_idx_ff <= 3'h0;
							txo_ff <= !extra_bit ? 1'b1 : mp_fmt ? mpbt_ff :
								tx_parity_ff ^ tx_sh_ff[0] ^ fmt_ff[FMT_ODD];
						end
					end
				end
				T_EXTRA: begin
					if (tx_bit_end) begin
						tx_st_ff <= T_STOP;
						txo_ff <= 1'b1; // [R08]
					end
				end
				T_STOP: begin
					if (tx_bit_end) begin
						tx_idx_ff <= 3'h1;
						if (tx_idx_ff[0] || !fmt_ff[FMT_STOP2])
							tx_st_ff <= T_IDLE; // [R16]
					end
				end
				default: tx_st_ff <= T_IDLE;
			endcase
		end
	end

	// pins and request lines; pin released, serial_out_oe_n high, when not selected
	assign serial_out_pin = txo_ff;
	assign serial_out_oe_n = !(ctl_ff[CTL_TE] && pfn_ff[PFN_TX]); // [R14]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			tx_empty_irq <= 1'b0;
			tx_end_irq <= 1'b0;
		end else begin
			rx_full_irq <= ctl_ff[CTL_RIE] && rx_full_ff; // [R07]
			rx_error_irq <= ctl_ff[CTL_RIE] && (ovr_ff || frm_ff || par_ff);
			tx_empty_irq <= ctl_ff[CTL_TIE] && tx_empty_ff;
			tx_end_irq <= ctl_ff[CTL_TX_END_INT_ENABLE] && tend_ff;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rx_off_idle: assert property (!rx_go |=> rx_st_ff == R_IDLE) // [R01]
		else $error("receiver active while disabled");
	a_rx_off_keep: assert property ((!rx_go && !wr_sts) |=>
		$stable(rx_buf_ff) && $stable(sts[6:3])) // [R02]
		else $error("receive state changed while disabled");
	a_start_edge: assert property ((rx_st_ff == R_IDLE && rx_go && fall)
		|=> rx_st_ff == R_START) // [R03]
		else $error("start edge missed");
	a_no_wait_take: assert property ((rx_done && !id_eff && !rx_full_ff)
		|=> rx_full_ff) // [R04]
		else $error("character not taken");
	a_addr_clears: assert property ((rx_done && id_eff && rx_mpb_ff && !wr_ctl)
		|=> !ctl_ff[CTL_ID_WAIT_ENABLE] && mpb_ff && rx_full_ff) // [R05]
		else $error("address character did not end wait");
	a_wait_blocks: assert property ((rx_done && id_eff && !rx_mpb_ff && !wr_sts)
		|=> $stable(rx_buf_ff) && $stable(sts[6:4])) // [R06]
		else $error("data passed while waiting for id");
	a_false_start: assert property ((rx_st_ff == R_START && samp && rx_lvl_ff
		&& rx_go) |=> rx_st_ff == R_IDLE) // [R09]
		else $error("glitch accepted as start");
	a_start_low: assert property ((tx_st_ff == T_IDLE && tx_load)
		|=> !txo_ff [*2]) // [R08]
		else $error("start bit not low");
	a_tx_off: assert property (!ctl_ff[CTL_TE] |=> tx_empty_ff && txo_ff &&
		tx_st_ff == T_IDLE) // [R11]
		else $error("tx_on clear did not reset transmitter");
	a_pin_gate: assert property (!pfn_ff[PFN_TX] |-> serial_out_oe_n) // [R14]
		else $error("output pin driven while not selected");

	c_rx_char: cover property (rx_done && accept && !rx_full_ff);
	c_overrun: cover property (rx_done && accept && rx_full_ff);
	c_id_match: cover property (rx_done && id_eff && rx_mpb_ff);
	c_tx_end: cover property ($rose(tend_ff));
endmodule : sart_top
`default_nettype wire

// ### hdl/sart_pkg.sv
// Operation
// (R01) receiver runs only while rx_on set
// (R02) rx_on clear keeps receive flags, buffer
// (R03) start bit begins reception once enabled
// (R04) id wait only async multiproc format
// (R05) id wait cleared by software or address
// (R06) id wait blocks transfer, errors, flags
// (R07) address character clears wait, raises flags
// (R08) idle high, start, lsb first, parity, stop
// (R09) align start edge, sample eighth of sixteen
// (R10) independent double buffered transmit and receive
// (R11) tx_on clear empties and resets shifter
// (R12) software configures with everything disabled
// (R13) software waits one bit, then enables
// (R14) pins active per pin function and enables
// (R15) prescaler then divisor plus one sets rate
// (R16) format register sets parity, length, stops
package sart_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_FMT = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_CTL = 8'h08;
	localparam logic [7:0] OFF_TXD = 8'h0c;
	localparam logic [7:0] OFF_STS = 8'h10;
	localparam logic [7:0] OFF_RXD = 8'h14;
	localparam logic [7:0] OFF_PFN = 8'h18;
	// serial_format_reg fields, bits 1:0 hold prescaler select
	localparam int FMT_SYNC = 7;
	localparam int FMT_CHR7 = 6;
	localparam int FMT_PEN = 5;
	localparam int FMT_ODD = 4;
	localparam int FMT_STOP2 = 3;
	localparam int FMT_MP = 2;
	// serial_control_reg fields
	localparam int CTL_TIE = 7;
	localparam int CTL_RIE = 6;
	localparam int CTL_TE = 5;
	localparam int CTL_RE = 4;
	localparam int CTL_ID_WAIT_ENABLE = 3;
	localparam int CTL_TX_END_INT_ENABLE = 2;
	// serial_status_reg fields
	localparam int STS_TX_EMPTY_FLAG = 7;
	localparam int STS_RX_FULL_FLAG = 6;
	localparam int STS_OVERRUN_FLAG = 5;
	localparam int STS_FER = 4;
	localparam int STS_PER = 3;
	localparam int STS_TEND = 2;
	localparam int STS_MPB = 1;
	localparam int STS_MPBT = 0;
	// pin function fields
	localparam int PFN_TX = 0;
	localparam int PFN_RX = 1;
	// reset values
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'hff;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [1:0] PFN_RST = 2'h0;
	// oversampling: sixteen ticks a bit, sample on the eighth
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
	// prescaler: divide by 4 to the power n
	localparam logic [5:0] PRE_MAX = 6'h3f;
	localparam logic [3:0] PRE_SHIFT = 4'h6;
	typedef enum logic [4:0] {
		R_IDLE = 5'h01, R_START = 5'h02, R_DATA = 5'h04,
		R_EXTRA = 5'h08, R_STOP = 5'h10
	} sart_rx_e;
	typedef enum logic [4:0] {
		T_IDLE = 5'h01, T_START = 5'h02, T_DATA = 5'h04,
		T_EXTRA = 5'h08, T_STOP = 5'h10
	} sart_tx_e;
endpackage : sart_pkg

// ### hdl/sart_baud.sv
`timescale 1ns/1ps
`default_nettype none
module sart_baud (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] pre_sel,
	input wire logic [7:0] divisor,
	output logic tick
);
	import sart_pkg::*;
	logic [5:0] pre_ff;
	logic [7:0] div_ff;
	logic [5:0] pre_last;
	logic pre_done;

	// 4^n - 1 by shifting an all-ones count
	assign pre_last = PRE_MAX >> (PRE_SHIFT - {1'b0, pre_sel, 1'b0}); // [R15]
	assign pre_done = (pre_ff >= pre_last);
	assign tick = pre_done && (div_ff >= divisor);

	// prescaler, then divisor plus one; >= survives a smaller reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 6'h00;
			div_ff <= 8'h00;
		end else begin
			pre_ff <= pre_done ? 6'h00 : pre_ff + 6'h01; // [R15]
			if (tick)
				div_ff <= 8'h00;
			else if (pre_done)
				div_ff <= div_ff + 8'h01; // [R15]
		end
	end
endmodule : sart_baud
`default_nettype wire

// ### tb/sart_remote.sv
`timescale 1ns/1ps
`default_nettype none
// far station: drives our receive line, listens to our transmit line
module sart_remote (
	input wire logic pclk,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1; // line idles at mark

	// start low, eight bits lsb first, optional extra bit, stop
	task automatic send_char(input logic [7:0] d, input logic xen,
		input logic xv, input logic sv, input int bc);
		@(posedge pclk);
		line_out <= 1'b0; // start bit
		repeat (bc) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			line_out <= d[i]; // lsb first
			repeat (bc) @(posedge pclk);
		end
		if (xen) begin
			line_out <= xv;
			repeat (bc) @(posedge pclk);
		end
		line_out <= sv; // a low stop only when a test asks for it
		repeat (bc) @(posedge pclk);
		line_out <= 1'b1;
		repeat (bc) @(posedge pclk);
	endtask : send_char

	// mid-bit sampling; a missing start leaves ok low
	task automatic recv_char(output logic [7:0] d, output logic ok,
		input int bc);
		int k;
		ok = 1'b0;
		d = 8'h00;
		k = 0;
		while (line_in !== 1'b0 && k < 4000) begin
			@(posedge pclk);
			k++;
		end
		if (k < 4000) begin
			repeat (bc / 2) @(posedge pclk);
			ok = (line_in === 1'b0);
			for (int i = 0; i < 8; i++) begin
				repeat (bc) @(posedge pclk);
				d[i] = line_in;
			end
			repeat (bc) @(posedge pclk);
			ok = ok && (line_in === 1'b1); // stop is high
		end
	endtask : recv_char
endmodule : sart_remote
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sart_pkg::*;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic pready, pslverr, err, ok, rx_line, tx_line, tx_oe_n;
	logic rx_full_irq, rx_error_irq, tx_empty_irq, tx_end_irq;
	logic [7:0] a, b, got;
	wire logic tx_w;
	int n_errors, n_tests;

	// undriven transmit pin reads as the pull-up level
	assign tx_w = tx_oe_n ? 1'b1 : tx_line;

	sart_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_in_pin(rx_line),
		.serial_out_pin(tx_line), .serial_out_oe_n(tx_oe_n),
		.rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
		.tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq));
	sart_remote rem (.pclk(pclk), .line_in(tx_w), .line_out(rx_line));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; pready is waited for under a bound
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		if (k == 20) begin
			n_errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the write land before the caller looks at outputs
		@(negedge pclk);
	endtask : apb

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// expected receive flags, bits 6:3 of the status word
	function automatic logic [31:0] fl(input logic f, input logic o,
		input logic fe, input logic pe);
		logic [31:0] v;
		v = 32'h0;
		v[STS_RX_FULL_FLAG] = f;
		v[STS_OVERRUN_FLAG] = o;
		v[STS_FER] = fe;
		v[STS_PER] = pe;
		return v;
	endfunction : fl

	// send one character, then look at the receive flags
	task automatic rx_try(input logic [7:0] d, input logic xen,
		input logic xv, input logic sv, input int bc);
		rem.send_char(d, xen, xv, sv, bc);
		apb(1'b0, OFF_STS, 8'h00);
	endtask : rx_try

	initial begin
		n_errors = 0;
		n_tests = 0;
		seed = 32'h00007d4a;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// reset state and an unmapped offset
		apb(1'b0, OFF_CTL, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, 8'h1c, 8'h00);
		chk({31'h0, err}, 32'h1);
		chk({31'h0, tx_oe_n}, 32'h1);
		// tx enabled but pin not handed over: stays released
		apb(1'b1, OFF_DIV, 8'h01);
		apb(1'b1, OFF_CTL, 8'h20);
		chk({31'h0, tx_oe_n}, 32'h1);
		apb(1'b1, OFF_PFN, 8'h03);
		repeat (32) @(posedge pclk);
		apb(1'b1, OFF_CTL, 8'h70);
		chk({31'h0, tx_oe_n}, 32'h0);
		// random characters both ways at once, 32 clocks a bit
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			a = seed[7:0];
			b = seed[15:8];
			apb(1'b1, OFF_TXD, b);
			fork
				rem.send_char(a, 1'b0, 1'b0, 1'b1, 32);
				rem.recv_char(got, ok, 32);
			join
			chk({24'h0, got}, {24'h0, b});
			chk({31'h0, ok & rx_full_irq}, 32'h1);
			apb(1'b0, OFF_RXD, 8'h00);
			chk(rd, {24'h0, a});
			apb(1'b1, OFF_STS, 8'h00);
		end
		// wrong even parity, then a low stop bit
		apb(1'b1, OFF_CTL, 8'h00);
		apb(1'b1, OFF_FMT, 8'h20);
		apb(1'b1, OFF_CTL, 8'h50);
		rx_try(8'h5a, 1'b1, 1'b1, 1'b1, 32);
		chk(rd & 32'h08, fl(0, 0, 0, 1));
		chk({31'h0, rx_error_irq}, 32'h1);
		apb(1'b1, OFF_STS, 8'h00);
		rx_try(8'h33, 1'b1, 1'b0, 1'b0, 32);
		chk(rd & 32'h10, fl(0, 0, 1, 0));
		// two characters unread: overrun keeps the first
		apb(1'b1, OFF_STS, 8'h00);
		rx_try(8'hc3, 1'b1, 1'b0, 1'b1, 32);
		rx_try(8'h18, 1'b1, 1'b0, 1'b1, 32);
		chk(rd & 32'h78, fl(1, 1, 0, 0));
		// receiver off: flags and buffer kept, line ignored
		apb(1'b1, OFF_CTL, 8'ha4);
		apb(1'b1, OFF_TXD, 8'h00);
		repeat (100) @(posedge pclk);
		// holding register already moved on, frame still shifting
		chk({31'h0, tx_empty_irq}, 32'h1);
		chk({31'h0, tx_end_irq}, 32'h0);
		apb(1'b1, OFF_CTL, 8'h00);
		chk({31'h0, tx_w}, 32'h1);
		rx_try(8'h7e, 1'b1, 1'b0, 1'b1, 32);
		chk(rd & 32'hf8, 32'h80 | fl(1, 1, 0, 0));
		chk({31'h0, tx_line}, 32'h1);
		apb(1'b0, OFF_RXD, 8'h00);
		chk(rd, 32'hc3);
		// id wait: non-address dropped, address accepted
		apb(1'b1, OFF_STS, 8'h00);
		apb(1'b1, OFF_FMT, 8'h04);
		apb(1'b1, OFF_CTL, 8'h58);
		rx_try(8'h11, 1'b1, 1'b0, 1'b1, 32);
		chk(rd & 32'h40, 32'h0);
		rx_try(8'h22, 1'b1, 1'b1, 1'b1, 32);
		chk(rd & 32'h42, 32'h42);
		apb(1'b0, OFF_CTL, 8'h00);
		chk(rd, 32'h50);
		apb(1'b0, OFF_RXD, 8'h00);
		chk(rd, 32'h22);
		// seven bits, odd parity: top bit of the word is the parity
		apb(1'b1, OFF_CTL, 8'h00);
		apb(1'b1, OFF_FMT, 8'h70);
		apb(1'b1, OFF_STS, 8'h00);
		repeat (32) @(posedge pclk);
		apb(1'b1, OFF_CTL, 8'h10);
		rx_try(8'hc1, 1'b0, 1'b0, 1'b1, 32);
		chk(rd & 32'h78, fl(1, 0, 0, 0));
		apb(1'b0, OFF_RXD, 8'h00);
		chk(rd, 32'h41);
		// id wait ignored without multiprocessor format, prescaler 4
		apb(1'b1, OFF_CTL, 8'h00);
		apb(1'b1, OFF_STS, 8'h00);
		apb(1'b1, OFF_FMT, 8'h01);
		apb(1'b1, OFF_DIV, 8'h00);
		apb(1'b1, OFF_CTL, 8'h58);
		seed = xs(seed);
		rx_try(seed[7:0], 1'b0, 1'b0, 1'b1, 64);
		chk(rd & 32'h40, 32'h40);
		apb(1'b0, OFF_RXD, 8'h00);
		chk(rd, {24'h0, seed[7:0]});
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
